// file: hw/cpu_decode_pkg.sv
package cpu_decode_pkg;

  typedef enum logic [3:0] {
    direct_page_mode,
    extended_address_mode,
    immediate_operand_mode,
    inherent_mode,
    indexed_no_offset_mode,
    indexed_short_offset_mode,
    indexed_long_offset_mode,
    indexed_postinc_mode,
    indexed_short_postinc_mode,
    relative_branch_mode,
    stack_short_offset_mode,
    stack_long_offset_mode
  } addr_mode_type;

  typedef enum logic [3:0] {
    cls_bit_test_branch,
    cls_bit_update,
    cls_rel_branch,
    cls_read_modify_write,
    cls_control,
    cls_alu_memory,
    cls_compare_branch,
    cls_multiply_divide,
    cls_outside
  } instr_class_type;

  typedef enum logic [2:0] {
    cyc_idle,
    cyc_free,
    cyc_program,
    cyc_read,
    cyc_write,
    cyc_push,
    cyc_pop,
    cyc_vector
  } bus_cycle_type;

  typedef struct packed {
    logic            in_table;
    instr_class_type iclass;
    addr_mode_type   mode;
    logic [1:0]      length;
    logic [3:0]      cycles;
    logic [2:0]      pops;
    logic [2:0]      pushes;
    logic            vector;
    logic            writes;
  } decode_type;

  typedef struct packed {
    bus_cycle_type kind;
    logic [15:0]   addr;
    logic          write;
    logic [7:0]    wdata;
  } bus_req_type;

  // Opcode map layout
  localparam logic [3:0]  LAST_ROW_NIBBLE = 4'h5;
  localparam logic [1:0]  MAX_OPERANDS    = 2'h2;

  // Vector page and the low address of the software vector high byte
  localparam logic [7:0]  VECTOR_PAGE     = 8'hFF;
  localparam logic [7:0]  SWI_VECTOR_LO   = 8'hFC;

  // Stack traffic of the control row
  localparam logic [2:0]  INT_RETURN_POPS = 3'h5;
  localparam logic [2:0]  RTS_POPS        = 3'h2;
  localparam logic [2:0]  SWI_PUSHES      = 3'h5;
  localparam logic [1:0]  VECTOR_BYTES    = 2'h2;

  // Values after reset
  localparam logic [15:0] PC_RESET        = 16'h0000;
  localparam logic [15:0] ADDR_RESET      = 16'h0000;
  localparam logic [7:0]  BYTE_RESET      = 8'h00;
  localparam logic [3:0]  COUNT_RESET     = 4'h0;

endpackage : cpu_decode_pkg

// file: hw/opcode_decode_rom.sv
`timescale 1ns/100ps
module opcode_decode_rom (
  // Clock and reset
  input  wire logic                     clk_sys_in,
  input  wire logic                     srst_in,
  // Lookup
  input  wire logic                     load_in,
  input  wire logic [7:0]               opcode_in,
  output      cpu_decode_pkg::decode_type decode_out
);
  import cpu_decode_pkg::*;

  decode_type rom_q;
  decode_type rom_d;

  function automatic decode_type entry(input instr_class_type c,
                                       input addr_mode_type m,
                                       input logic [1:0] len,
                                       input logic [3:0] cyc,
                                       input logic wr);
    decode_type e;
    e = '0;
    e.in_table = 1'b1;
    e.iclass   = c;
    e.mode     = m;
    e.length   = len;
    e.cycles   = cyc;
    e.writes   = wr;
    return e;
  endfunction : entry

  function automatic decode_type lookup(input logic [7:0] op);
    decode_type e;
    e = '0;
    e.iclass = cls_outside;
    if (op[3:0] > LAST_ROW_NIBBLE) begin
      return e;
    end
    unique case (op[7:4])
      4'h0: e = entry(cls_bit_test_branch, direct_page_mode,
                      2'd3, 4'd5, 1'b0);
      4'h1: e = entry(cls_bit_update, direct_page_mode, 2'd2, 4'd5, 1'b1);
      4'h2: e = entry(cls_rel_branch, relative_branch_mode, 2'd2, 4'd3, 1'b0);
      4'h3: e = entry(cls_read_modify_write, direct_page_mode,
                      2'd2, 4'd5, 1'b1);
      4'h4: e = entry(cls_read_modify_write, inherent_mode, 2'd1, 4'd1, 1'b0);
      4'h5: e = entry(cls_read_modify_write, inherent_mode, 2'd1, 4'd1, 1'b0);
      4'h6: e = entry(cls_read_modify_write, indexed_short_offset_mode,
                      2'd2, 4'd5, 1'b1);
      4'h7: e = entry(cls_read_modify_write, indexed_no_offset_mode,
                      2'd1, 4'd4, 1'b1);
      4'h8: e = entry(cls_control, inherent_mode, 2'd1, 4'd1, 1'b0);
      4'h9: e = entry(cls_rel_branch, relative_branch_mode, 2'd2, 4'd3, 1'b0);
      4'hA: e = entry(cls_alu_memory, immediate_operand_mode,
                      2'd2, 4'd2, 1'b0);
      4'hB: e = entry(cls_alu_memory, direct_page_mode, 2'd2, 4'd3, 1'b0);
      4'hC: e = entry(cls_alu_memory, extended_address_mode,
                      2'd3, 4'd4, 1'b0);
      4'hD: e = entry(cls_alu_memory, indexed_long_offset_mode,
                      2'd3, 4'd4, 1'b0);
      4'hE: e = entry(cls_alu_memory, indexed_short_offset_mode,
                      2'd2, 4'd3, 1'b0);
      4'hF: e = entry(cls_alu_memory, indexed_no_offset_mode,
                      2'd1, 4'd3, 1'b0);
    endcase
    case (op)
      8'h31: e = entry(cls_compare_branch, direct_page_mode, 2'd3, 4'd5, 1'b0);
      8'h41: e = entry(cls_compare_branch, immediate_operand_mode,
                       2'd3, 4'd4, 1'b0);
      8'h51: e = entry(cls_compare_branch, immediate_operand_mode,
                       2'd3, 4'd4, 1'b0);
      8'h61: e = entry(cls_compare_branch, indexed_short_postinc_mode,
                       2'd3, 4'd5, 1'b0);
      8'h71: e = entry(cls_compare_branch, indexed_postinc_mode,
                       2'd2, 4'd5, 1'b0);
      8'h32: e = entry(cls_alu_memory, extended_address_mode,
                       2'd3, 4'd5, 1'b0);
      8'h42: e = entry(cls_multiply_divide, inherent_mode,
                       2'd1, 4'd5, 1'b0);
      8'h52: e = entry(cls_multiply_divide, inherent_mode,
                       2'd1, 4'd6, 1'b0);
      8'h62: e = entry(cls_alu_memory, inherent_mode, 2'd1, 4'd1, 1'b0);
      8'h72: e = entry(cls_alu_memory, inherent_mode, 2'd1, 4'd1, 1'b0);
      8'h35: e = entry(cls_alu_memory, direct_page_mode, 2'd2, 4'd4, 1'b1);
      8'h45: e = entry(cls_alu_memory, immediate_operand_mode,
                       2'd3, 4'd3, 1'b0);
      8'h55: e = entry(cls_alu_memory, direct_page_mode, 2'd2, 4'd4, 1'b0);
      8'h65: e = entry(cls_alu_memory, immediate_operand_mode,
                       2'd3, 4'd3, 1'b0);
      8'h75: e = entry(cls_alu_memory, direct_page_mode, 2'd2, 4'd5, 1'b0);
      8'h80: begin
        e = entry(cls_control, inherent_mode, 2'd1, 4'd9, 1'b0);
        e.pops = INT_RETURN_POPS;
      end
      8'h81: begin
        e = entry(cls_control, inherent_mode, 2'd1, 4'd6, 1'b0);
        e.pops = RTS_POPS;
      end
      8'h82: e = entry(cls_control, inherent_mode, 2'd1, 4'd5, 1'b0);
      8'h83: begin
        e = entry(cls_control, inherent_mode, 2'd1, 4'd11, 1'b0);
        e.pushes = SWI_PUSHES;
        e.vector = 1'b1;
      end
      8'h94: e = entry(cls_control, inherent_mode, 2'd1, 4'd2, 1'b0);
      8'h95: e = entry(cls_control, inherent_mode, 2'd1, 4'd2, 1'b0);
      default: begin
      end
    endcase
    return e;
  endfunction : lookup

  always_comb begin
    rom_d = load_in ? lookup(opcode_in) : rom_q;
  end

  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      rom_q <= '0;
    end else begin
      rom_q <= rom_d;
    end
  end

  assign decode_out = rom_q;

endmodule : opcode_decode_rom

// file: hw/cpu_opcode_cycle_decoder.sv
// Overview of operation
// - Free cycle is one clock long and shows as a read.
// - Program fetch reads next sequential byte and bumps fetch pointer.
// - Push writes one byte to stack; pop reads one byte.
// - Vector bytes come from the top page, high byte first.
// - Operands are zero, one or two bytes depending on addressing mode.
// - Relative forms carry one offset byte added to program counter.
// - Indexed modes: no offset, 8-bit unsigned, 16-bit added to H:X.
// - Two post-increment indexed modes bump H:X after the access.
// - Stack modes add an 8-bit or 16-bit offset to SP.
// - Opcodes 41 and 51 are three bytes, four cycles.
// - Opcode 71 two bytes five cycles; 61 three bytes five cycles.
// - Opcode 81 is one inherent byte taking six cycles.
// - Compare A1 immediate 2/2, C1 extended 3/4, E1 short indexed 2/3.
// - Opcode 01 is three bytes, five cycles.
// - E1 and A1 are two bytes; three and two cycles.
`timescale 1ns/100ps
module cpu_opcode_cycle_decoder (
  // Clock and reset
  input  wire logic                          clk_sys_in,
  input  wire logic                          srst_in,
  // Opcode from the fetch path
  input  wire logic                          opcode_valid_in,
  input  wire logic [7:0]                    opcode_in,
  output      logic                          opcode_ready_out,
  // Datapath state
  input  wire logic [15:0]                   index_hx_in,
  input  wire logic [15:0]                   stack_ptr_in,
  input  wire logic                          pc_load_in,
  input  wire logic [15:0]                   pc_value_in,
  input  wire logic [7:0]                    write_data_in,
  // Decode results
  output      cpu_decode_pkg::decode_type    decode_out,
  output      logic                          out_of_table_out,
  // System bus
  output      cpu_decode_pkg::bus_req_type   bus_out,
  input  wire logic [7:0]                    read_data_in,
  // Completion
  output      logic                          done_out,
  output      logic                          index_inc_out,
  output      logic [15:0]                   branch_target_out,
  output      logic [15:0]                   eff_addr_out,
  output      logic [15:0]                   pc_out
);
  import cpu_decode_pkg::*;

  typedef enum logic [1:0] {st_idle, st_decode, st_run} seq_state_type;

  seq_state_type state_q, state_d;
  decode_type    dec;
  logic [3:0]    cyc_q, cyc_d;
  logic [15:0]   pc_q, pc_d;
  logic [15:0]   stk_q, stk_d;
  logic [1:0]    vec_q, vec_d;
  logic [7:0]    byte0_q, byte0_d;
  logic [7:0]    byte1_q, byte1_d;
  logic          slot_vld_q, slot_vld_d;
  logic          slot_idx_q, slot_idx_d;
  bus_req_type   bus_q, bus_d;
  logic          done_q, done_d;
  logic          oot_q, oot_d;
  logic          inc_q, inc_d;
  logic [15:0]   tgt_q, tgt_d;
  logic [15:0]   ea_q, ea_d;

  logic [7:0]    cur0, cur1, rel;
  logic [15:0]   ea_now;
  bus_cycle_type kind;

  // Table sits one flop behind the opcode strobe
  opcode_decode_rom u_rom (
    .clk_sys_in (clk_sys_in),
    .srst_in    (srst_in),
    .load_in    (opcode_valid_in && (state_q == st_idle)),
    .opcode_in  (opcode_in),
    .decode_out (dec)
  );

  function automatic logic [15:0] effective_addr(input addr_mode_type m,
                                                 input logic [7:0] b0,
                                                 input logic [7:0] b1,
                                                 input logic [15:0] hx,
                                                 input logic [15:0] sp);
    logic [15:0] r;
    r = ADDR_RESET;
    unique case (m)
      direct_page_mode:           r = {8'h00, b0};
      extended_address_mode:      r = {b0, b1};
      indexed_no_offset_mode,
      indexed_postinc_mode:       r = hx;
      indexed_short_offset_mode,
      indexed_short_postinc_mode: r = hx + {8'h00, b0};
      indexed_long_offset_mode:   r = hx + {b0, b1};
      stack_short_offset_mode:    r = sp + {8'h00, b0};
      stack_long_offset_mode:     r = sp + {b0, b1};
      immediate_operand_mode,
      inherent_mode,
      relative_branch_mode:       r = ADDR_RESET;
    endcase
    return r;
  endfunction : effective_addr

  // Modes whose operand lives in memory, not in the opcode stream
  function automatic logic has_memory_operand(input addr_mode_type m);
    return !(m == immediate_operand_mode || m == inherent_mode ||
             m == relative_branch_mode);
  endfunction : has_memory_operand

  // Bus activity of cycle k within the instruction
  // Order: operands, pops, pushes, vectors, read, then free; a write takes the cycle before the last
  // The last cycle always fetches the next opcode
  function automatic bus_cycle_type cycle_kind(input decode_type d,
                                               input logic [3:0] k);
    logic [3:0] opnds;
    logic [3:0] last;
    bus_cycle_type t;

    opnds = {2'b00, d.length} - 4'd1;
    last  = d.cycles - 4'd1;
    t     = cyc_free;

    if (k < opnds || k == last) begin
      t = cyc_program;
    end else if (k < opnds + {1'b0, d.pops}) begin
      t = cyc_pop;
    end else if (k < opnds + {1'b0, d.pushes}) begin
      t = cyc_push;
    end else if (d.vector &&
                 k < opnds + {1'b0, d.pushes} + {2'b00, VECTOR_BYTES}) begin
      t = cyc_vector;
    end else if (has_memory_operand(d.mode) && k == opnds &&
                 d.iclass != cls_bit_test_branch) begin
      t = cyc_read;
    end else if (d.writes && k == last - 4'd1) begin
      t = cyc_write;
    end
    return t;
  endfunction : cycle_kind

  // Forward the operand byte that is on the bus this cycle
  always_comb begin
    cur0 = byte0_q;
    cur1 = byte1_q;
    if (slot_vld_q && !slot_idx_q) begin
      cur0 = read_data_in;
    end
    if (slot_vld_q && slot_idx_q) begin
      cur1 = read_data_in;
    end
    rel    = dec.length[0] ? cur1 : cur0;
    ea_now = effective_addr(dec.mode, cur0, cur1, index_hx_in, stk_q);
    kind   = cycle_kind(dec, cyc_q);
  end

  always_comb begin
    state_d    = state_q;
    cyc_d      = cyc_q;
    pc_d       = pc_q;
    stk_d      = stk_q;
    vec_d      = vec_q;
    byte0_d    = cur0;
    byte1_d    = cur1;
    slot_vld_d = 1'b0;
    slot_idx_d = 1'b0;
    bus_d      = '0;
    bus_d.kind = cyc_idle;
    bus_d.addr = pc_q;
    done_d     = 1'b0;
    oot_d      = 1'b0;
    inc_d      = 1'b0;
    tgt_d      = tgt_q;
    ea_d       = ea_q;

    unique case (state_q)
      st_idle: begin
        if (opcode_valid_in) begin
          state_d = st_decode;
        end
      end
      st_decode: begin
        byte0_d = BYTE_RESET;
        byte1_d = BYTE_RESET;
        if (!dec.in_table) begin
          oot_d   = 1'b1;
          state_d = st_idle;
        end else begin
          state_d = st_run;
          cyc_d   = COUNT_RESET;
          stk_d   = stack_ptr_in;
          vec_d   = 2'h0;
        end
      end
      st_run: begin
        ea_d       = ea_now;
        bus_d.kind = kind;
        unique case (kind)
          cyc_program: begin
            bus_d.addr = pc_q;
            pc_d       = pc_q + 16'h0001;
            if (cyc_q < {2'b00, dec.length} - 4'd1) begin
              slot_vld_d = 1'b1;
              slot_idx_d = cyc_q[0];
            end
          end
          cyc_pop: begin
            bus_d.addr = stk_q + 16'h0001;
            stk_d      = stk_q + 16'h0001;
          end
          cyc_push: begin
            bus_d.addr  = stk_q;
            bus_d.write = 1'b1;
            bus_d.wdata = write_data_in;
            stk_d       = stk_q - 16'h0001;
          end
          cyc_vector: begin
            // High byte first, so the low address comes first
            bus_d.addr = {VECTOR_PAGE, SWI_VECTOR_LO + {6'h00, vec_q}};
            vec_d      = vec_q + 2'h1;
          end
          cyc_read: begin
            bus_d.addr = ea_now;
          end
          cyc_write: begin
            bus_d.addr  = ea_q;
            bus_d.write = 1'b1;
            bus_d.wdata = write_data_in;
          end
          cyc_free: begin
            // Free cycle still drives a harmless read of the fetch pointer
            bus_d.addr = pc_q;
          end
          cyc_idle: begin
            bus_d.addr = pc_q;
          end
        endcase
        // Done rides with the last fetch so ready returns at once
        if (cyc_q == dec.cycles - 4'd1) begin
          done_d  = 1'b1;
          state_d = st_idle;
          // pc_q already points past the instruction here
          tgt_d   = pc_q + {{8{rel[7]}}, rel};
          inc_d   = (dec.mode == indexed_postinc_mode) ||
                    (dec.mode == indexed_short_postinc_mode);
        end else begin
          cyc_d = cyc_q + 4'd1;
        end
      end
    endcase
    // Datapath redirect wins over a sequential fetch
    if (pc_load_in) begin
      pc_d = pc_value_in;
    end
  end

  // Reset leaves the bus idle so memory sees no stray access
  always_ff @(posedge clk_sys_in) begin
    if (srst_in) begin
      state_q    <= st_idle;
      cyc_q      <= COUNT_RESET;
      pc_q       <= PC_RESET;
      stk_q      <= ADDR_RESET;
      vec_q      <= 2'h0;
      byte0_q    <= BYTE_RESET;
      byte1_q    <= BYTE_RESET;
      slot_vld_q <= 1'b0;
      slot_idx_q <= 1'b0;
      bus_q      <= '0;
      done_q     <= 1'b0;
      oot_q      <= 1'b0;
      inc_q      <= 1'b0;
      tgt_q      <= ADDR_RESET;
      ea_q       <= ADDR_RESET;
    end else begin
      state_q    <= state_d;
      cyc_q      <= cyc_d;
      pc_q       <= pc_d;
      stk_q      <= stk_d;
      vec_q      <= vec_d;
      byte0_q    <= byte0_d;
      byte1_q    <= byte1_d;
      slot_vld_q <= slot_vld_d;
      slot_idx_q <= slot_idx_d;
      bus_q      <= bus_d;
      done_q     <= done_d;
      oot_q      <= oot_d;
      inc_q      <= inc_d;
      tgt_q      <= tgt_d;
      ea_q       <= ea_d;
    end
  end

  assign opcode_ready_out  = (state_q == st_idle);
  assign decode_out        = dec;
  assign out_of_table_out  = oot_q;
  assign bus_out           = bus_q;
  assign done_out          = done_q;
  assign index_inc_out     = inc_q;
  assign branch_target_out = tgt_q;
  assign eff_addr_out      = ea_q;
  assign pc_out            = pc_q;

endmodule : cpu_opcode_cycle_decoder

// file: tb/cpu_opcode_cycle_decoder_sva.sv
`timescale 1ns/100ps
module decoder_bus_checker (
  // Clock, reset and opcode handshake
  input  wire logic                        clk_sys_in,
  input  wire logic                        srst_in,
  input  wire logic                        opcode_valid_in,
  input  wire logic [7:0]                  opcode_in,
  input  wire logic                        opcode_ready_out,
  input  wire logic                        pc_load_in,
  input  wire logic [7:0]                  write_data_in,
  // Decode results and bus
  input  wire cpu_decode_pkg::decode_type  decode_out,
  input  wire logic                        out_of_table_out,
  input  wire cpu_decode_pkg::bus_req_type bus_out,
  input  wire logic                        done_out,
  input  wire logic                        index_inc_out
);
  import cpu_decode_pkg::*;
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (srst_in);

  property p_free_read;
    bus_out.kind == cyc_free |-> !bus_out.write;
  endproperty
  a_free_read: assert property (p_free_read)
    else $error("free cycle shown as a write");

  property p_prog_step;
    bus_out.kind == cyc_program && $past(bus_out.kind) == cyc_program &&
      !$past(pc_load_in) |->
      !bus_out.write && bus_out.addr == $past(bus_out.addr) + 16'h0001;
  endproperty
  a_prog_step: assert property (p_prog_step)
    else $error("program fetch not at next address");

  property p_push_write;
    bus_out.kind == cyc_push |->
      bus_out.write && bus_out.wdata == $past(write_data_in) &&
      ($past(bus_out.kind) != cyc_push ||
       bus_out.addr == $past(bus_out.addr) - 16'h0001);
  endproperty
  a_push_write: assert property (p_push_write)
    else $error("push not a single descending write");

  property p_pop_read;
    bus_out.kind == cyc_pop |-> !bus_out.write &&
      ($past(bus_out.kind) != cyc_pop ||
       bus_out.addr == $past(bus_out.addr) + 16'h0001);
  endproperty
  a_pop_read: assert property (p_pop_read)
    else $error("pop not a single ascending read");

  property p_vector_top;
    bus_out.kind == cyc_vector |->
      bus_out.addr[15:8] == 8'hFF && !bus_out.write;
  endproperty
  a_vector_top: assert property (p_vector_top)
    else $error("vector read outside top page");

  property p_vector_order;
    bus_out.kind == cyc_vector && $past(bus_out.kind) != cyc_vector |=>
      bus_out.kind == cyc_vector && bus_out.addr == $past(bus_out.addr) + 1;
  endproperty
  a_vector_order: assert property (p_vector_order)
    else $error("vector bytes out of order");

  property p_table_flag;
    opcode_valid_in && opcode_ready_out |-> ##2
      decode_out.in_table == ($past(opcode_in[3:0], 2) <= 4'h5);
  endproperty
  a_table_flag: assert property (p_table_flag)
    else $error("in-table flag wrong for opcode");

  property p_oot_idle;
    out_of_table_out |-> !decode_out.in_table && bus_out.kind == cyc_idle;
  endproperty
  a_oot_idle: assert property (p_oot_idle)
    else $error("outside opcode ran bus cycles");

  property p_inc_done;
    index_inc_out |-> done_out && (decode_out.mode == indexed_postinc_mode ||
      decode_out.mode == indexed_short_postinc_mode);
  endproperty
  a_inc_done: assert property (p_inc_done)
    else $error("index bump outside post-increment mode");

  property p_busy_after_take;
    opcode_valid_in && opcode_ready_out |=> !opcode_ready_out;
  endproperty
  a_busy_after_take: assert property (p_busy_after_take)
    else $error("ready stayed high after opcode taken");

  property p_done_on_bus;
    done_out |-> bus_out.kind != cyc_idle;
  endproperty
  a_done_on_bus: assert property (p_done_on_bus)
    else $error("done without a bus cycle");
endmodule : decoder_bus_checker

bind cpu_opcode_cycle_decoder decoder_bus_checker chk_u (
  .clk_sys_in, .srst_in, .opcode_valid_in, .opcode_in, .opcode_ready_out,
  .pc_load_in, .write_data_in, .decode_out, .out_of_table_out, .bus_out,
  .done_out, .index_inc_out);

// file: tb/bus_memory_model.sv
`timescale 1ns/100ps
module bus_memory_model (
  // Clock
  input  wire logic                        clk_sys_in,
  // Bus from the decoder
  input  wire cpu_decode_pkg::bus_req_type bus_in,
  output      logic [7:0]                  read_data_out
);
  import cpu_decode_pkg::*;
  logic [7:0] mem [0:65535];
  logic [7:0] last_q = 8'hA5;

  initial begin
    foreach (mem[i]) mem[i] = 8'h00;
  end

  // Idle bus shows a changing byte so a stale value is never trusted
  always_comb begin
    if (bus_in.kind == cyc_idle || bus_in.write) begin
      read_data_out = ~last_q;
    end else begin
      read_data_out = mem[bus_in.addr];
    end
  end

  always @(posedge clk_sys_in) begin
    last_q <= read_data_out;
    if (bus_in.write) begin
      mem[bus_in.addr] <= bus_in.wdata;
    end
  end
endmodule : bus_memory_model

// file: tb/test_cpu_opcode_cycle_decoder.sv
`timescale 1ns/100ps
`define check_eq(got, exp) begin \
  checked++; \
  if ((got) !== (exp)) begin \
    n_mismatch++; \
    $display("unexpected at %0t: got %0h expected %0h", $time, got, exp); \
  end \
end
module test_cpu_opcode_cycle_decoder;
  import cpu_decode_pkg::*;
  logic        clk_sys_in = 1'b0;
  logic        srst_in = 1'b1;
  logic        opcode_valid_in = 1'b0;
  logic [7:0]  opcode_in = 8'h00;
  logic [15:0] index_hx_in = 16'h0000;
  logic [15:0] stack_ptr_in = 16'h0100;
  logic        pc_load_in = 1'b0;
  logic [15:0] pc_value_in = 16'h0000;
  logic [7:0]  write_data_in = 8'h5A;
  logic [7:0]  read_data_in;
  decode_type  decode_out;
  bus_req_type bus_out;
  logic        opcode_ready_out, out_of_table_out, done_out, index_inc_out;
  logic [15:0] branch_target_out, eff_addr_out, pc_out;
  int          n_mismatch = 0;
  int          checked = 0;
  bus_req_type seen_q[$];
  logic        seen_oot, seen_inc;

  always #25 clk_sys_in = ~clk_sys_in;

  cpu_opcode_cycle_decoder dut_u (.clk_sys_in, .srst_in, .opcode_valid_in,
    .opcode_in, .opcode_ready_out, .index_hx_in, .stack_ptr_in, .pc_load_in,
    .pc_value_in, .write_data_in, .decode_out, .out_of_table_out, .bus_out,
    .read_data_in, .done_out, .index_inc_out, .branch_target_out,
    .eff_addr_out, .pc_out);
  bus_memory_model mem_u (.clk_sys_in, .bus_in(bus_out),
    .read_data_out(read_data_in));

  // Loads the fetch pointer, issues one opcode and logs its bus cycles
  task automatic run_op(input logic [7:0] op, input logic [15:0] start);
    seen_q = {};
    seen_oot = 1'b0;
    seen_inc = 1'b0;
    @(negedge clk_sys_in);
    pc_load_in = 1'b1;
    pc_value_in = start;
    @(negedge clk_sys_in);
    pc_load_in = 1'b0;
    opcode_valid_in = 1'b1;
    opcode_in = op;
    @(negedge clk_sys_in);
    opcode_valid_in = 1'b0;
    for (int k = 0; k < 40; k++) begin
      @(negedge clk_sys_in);
      if (bus_out.kind != cyc_idle) seen_q.push_back(bus_out);
      if (index_inc_out === 1'b1) seen_inc = 1'b1;
      if (out_of_table_out === 1'b1) seen_oot = 1'b1;
      if (done_out === 1'b1 || out_of_table_out === 1'b1) break;
    end
    @(negedge clk_sys_in);
  endtask : run_op

  task automatic t_cycle_table();
    logic [7:0] ops[13] = '{8'h41, 8'h51, 8'h71, 8'h61, 8'h81, 8'hA1,
                            8'hC1, 8'hE1, 8'h01, 8'h42, 8'h52, 8'h35, 8'h80};
    logic [1:0] lens[13] = '{2'h3, 2'h3, 2'h2, 2'h3, 2'h1, 2'h2,
                             2'h3, 2'h2, 2'h3, 2'h1, 2'h1, 2'h2, 2'h1};
    logic [3:0] cycs[13] = '{4'h4, 4'h4, 4'h5, 4'h5, 4'h6, 4'h2,
                             4'h4, 4'h3, 4'h5, 4'h5, 4'h6, 4'h4, 4'h9};
    addr_mode_type modes[13] = '{immediate_operand_mode,
      immediate_operand_mode, indexed_postinc_mode,
      indexed_short_postinc_mode, inherent_mode, immediate_operand_mode,
      extended_address_mode, indexed_short_offset_mode, direct_page_mode,
      inherent_mode, inherent_mode, direct_page_mode, inherent_mode};
    int n;
    for (int i = 0; i < 13; i++) begin
      run_op(ops[i], 16'h1000);
      `check_eq(decode_out.length, lens[i])
      `check_eq(decode_out.cycles, cycs[i])
      `check_eq(decode_out.mode, modes[i])
      `check_eq(seen_q.size(), int'(cycs[i]))
      `check_eq(seen_inc, 1'(i == 2 || i == 3))
      `check_eq(pc_out, 16'h1000 + 16'(lens[i]))
      n = 0;
      foreach (seen_q[j]) begin
        if (seen_q[j].kind == cyc_program) begin
          `check_eq(seen_q[j].addr, 16'h1000 + 16'(n))
          n++;
        end
      end
      `check_eq(n, int'(lens[i]))
    end
  endtask : t_cycle_table

  task automatic t_outside();
    logic [7:0] ops[4] = '{8'h06, 8'h1F, 8'h9E, 8'hFF};
    foreach (ops[i]) begin
      run_op(ops[i], 16'h1000);
      `check_eq(seen_oot, 1'b1)
      `check_eq(decode_out.in_table, 1'b0)
      `check_eq(seen_q.size(), 0)
    end
  endtask : t_outside

  task automatic t_stack();
    int np;
    int nv;
    np = 0;
    nv = 0;
    stack_ptr_in = 16'h0180;
    run_op(8'h83, 16'h3000);
    foreach (seen_q[i]) begin
      if (seen_q[i].kind == cyc_push) begin
        `check_eq(seen_q[i].addr, 16'h0180 - 16'(np))
        `check_eq(seen_q[i].wdata, write_data_in)
        np++;
      end
      if (seen_q[i].kind == cyc_vector) begin
        `check_eq(seen_q[i].addr, {VECTOR_PAGE, SWI_VECTOR_LO + 8'(nv)})
        nv++;
      end
    end
    `check_eq(np, int'(SWI_PUSHES))
    `check_eq(nv, int'(VECTOR_BYTES))
    np = 0;
    run_op(8'h81, 16'h3000);
    foreach (seen_q[i]) begin
      if (seen_q[i].kind == cyc_pop) begin
        `check_eq(seen_q[i].addr, 16'h0181 + 16'(np))
        `check_eq(seen_q[i].write, 1'b0)
        np++;
      end
    end
    `check_eq(np, int'(RTS_POPS))
  endtask : t_stack

  // Offset byte is the last operand; target counts from the next opcode
  task automatic t_branch();
    logic [7:0]  ops[3] = '{8'h20, 8'h20, 8'h01};
    logic [7:0]  offs[3] = '{8'h7F, 8'h80, 8'hF0};
    logic [15:0] nxt;
    for (int i = 0; i < 3; i++) begin
      nxt = (i == 2) ? 16'h2003 : 16'h2002;
      mem_u.mem[nxt - 16'h0001] = offs[i];
      run_op(ops[i], 16'h2001);
      `check_eq(branch_target_out, nxt + {{8{offs[i][7]}}, offs[i]})
    end
  endtask : t_branch

  task automatic t_indexed();
    index_hx_in = 16'h1234;
    mem_u.mem[16'h4001] = 8'h80;
    mem_u.mem[16'h4002] = 8'h02;
    run_op(8'hE1, 16'h4001);
    `check_eq(eff_addr_out, 16'h12B4)
    run_op(8'hD1, 16'h4001);
    `check_eq(eff_addr_out, 16'h9236)
    run_op(8'hF1, 16'h4001);
    `check_eq(eff_addr_out, 16'h1234)
  endtask : t_indexed

  task automatic t_reset_state();
    `check_eq(bus_out.kind, cyc_idle)
    `check_eq(opcode_ready_out, 1'b1)
    `check_eq(pc_out, PC_RESET)
  endtask : t_reset_state

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : close_out

  initial begin
    repeat (20) @(posedge clk_sys_in);
    @(negedge clk_sys_in);
    srst_in = 1'b0;
    t_reset_state();
    t_cycle_table();
    t_outside();
    t_stack();
    t_branch();
    t_indexed();
    close_out();
  end

  // Roughly 25 opcodes of under 20 cycles each; generous margin
  initial begin
    repeat (5000) @(posedge clk_sys_in);
    n_mismatch++;
    close_out();
  end
endmodule : test_cpu_opcode_cycle_decoder
